// >>> rtl/pmpc_checker.sv
// Purpose: Physical memory protection check for one hart
// Assumes: One request per cycle, result one cycle later
// Notes: Entries are written over plain ports by machine software
`timescale 1ns/10ps
`include "pmpc_regs.svh"
`default_nettype none
module pmpc_checker
    import pmpc_pkg::*;
#(
    // entry count and grain set per instance
    parameter int NUM_ENTRIES = `PMPC_DEF_ENTRIES,
    parameter int GRAIN = `PMPC_DEF_GRAIN
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic cfgWrEn,
    input wire logic [3:0] cfgWrIdx,
    input wire logic [7:0] cfgWrData,
    input wire logic addrWrEn,
    input wire logic [3:0] addrWrIdx,
    input wire logic [31:0] addrWrData,
    input wire logic reqValid,
    input wire logic [33:0] reqAddr,
    input wire logic [1:0] reqSizeLog,
    input wire logic [1:0] reqType,
    input wire logic [1:0] reqPriv,
    input wire logic reqPageWalk,
    input wire logic reqLast,
    output logic rspValid,
    output logic rspFault,
    output logic faultInstr,
    output logic faultLoad,
    output logic faultStore,
    output logic groupValid,
    output logic groupFault,
    output logic [15:0] lockedMask
);
    pmpc_state_t st_q;
    pmpc_state_t st_d;

    // Byte mask of a power-of-two region, grain bits forced to ones
    function automatic logic [33:0] regionMask(input logic [31:0] a,
                                               input logic na4);
        logic [32:0] ext;
        logic [32:0] ones;
        ext = {1'b0, a};
        if (GRAIN >= 2) begin
            ext = ext | ((33'h0_0000_0001 << (GRAIN - 1)) - 33'h0_0000_0001);
        end
        ones = ext ^ (ext + 33'h0_0000_0001);
        regionMask = na4 ? 34'h0_0000_0003 : {ones[31:0], 2'h3};
    endfunction : regionMask

    // Address write blocked by its own freeze or a frozen range-top above it
    function automatic logic addrBlocked(input pmpc_state_t s,
                                         input logic [3:0] idx);
        logic blk;
        blk = s.cfg[idx][`PMPC_BIT_L];
        if (32'(idx) + 1 < NUM_ENTRIES) begin
            blk = blk | (s.cfg[idx + 4'h1][`PMPC_BIT_L] &&
                s.cfg[idx + 4'h1][`PMPC_A_HI:`PMPC_A_LO] == PMPC_RANGE_TOP_MODE);
        end
        addrBlocked = blk;
    endfunction : addrBlocked

    logic [33:0] lastByte;
    logic [33:0] torMask;
    logic effMach;
    logic anyHit;
    logic winFull;
    logic [7:0] winCfg;
    logic permOk;
    logic fault;
    logic [NUM_ENTRIES-1:0] hitVec;
    logic [NUM_ENTRIES-1:0] fullVec;
    logic reservedSeen;

    // checked as the request arrives, never deferred
    assign effMach = (reqPriv == PMPC_PRIV_M) && !reqPageWalk;
    assign lastByte = reqAddr + ((`PMPC_PA_ONE << reqSizeLog) - `PMPC_PA_ONE);
    // Grain bits below the grain never steer range-top compares
    assign torMask = ~((`PMPC_PA_ONE << (GRAIN + `PMPC_WORD_SH)) - `PMPC_PA_ONE);

    // Every entry matched in parallel against first and last byte
    always_comb begin
        logic [33:0] lo;
        logic [33:0] hi;
        logic [33:0] msk;
        lo = `PMPC_PA_ZERO;
        hi = `PMPC_PA_ZERO;
        msk = `PMPC_PA_ZERO;
        hitVec = '0;
        fullVec = '0;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            lo = `PMPC_PA_ZERO;
            hi = `PMPC_PA_ZERO;
            msk = `PMPC_PA_ZERO;
            unique case (st_q.cfg[i][`PMPC_A_HI:`PMPC_A_LO])
                PMPC_MODE_OFF: begin
                    hitVec[i] = 1'b0;
                end
                PMPC_RANGE_TOP_MODE: begin
                    if (i > 0) begin
                        lo = {st_q.addr[i-1], 2'h0} & torMask;
                    end
                    hi = {st_q.addr[i], 2'h0} & torMask;
                    hitVec[i] = (reqAddr < hi) && (lastByte >= lo) && (lo < hi);
                    fullVec[i] = (reqAddr >= lo) && (lastByte < hi);
                end
                default: begin
                    msk = regionMask(st_q.addr[i],
                        st_q.cfg[i][`PMPC_A_HI:`PMPC_A_LO] == PMPC_FOUR_BYTE_ALIGNED);
                    lo = {st_q.addr[i], 2'h0} & ~msk;
                    hi = lo | msk;
                    hitVec[i] = (reqAddr <= hi) && (lastByte >= lo);
                    fullVec[i] = (reqAddr >= lo) && (lastByte <= hi);
                end
            endcase
        end
    end

    // lowest-numbered hit wins, loop runs downward
    always_comb begin
        anyHit = 1'b0;
        winFull = 1'b0;
        winCfg = `PMPC_CFG_RST;
        for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
            if (hitVec[i]) begin
                anyHit = 1'b1;
                winFull = fullVec[i];
                winCfg = st_q.cfg[i];
            end
        end
    end

    always_comb begin
        unique case (reqType)
            PMPC_ACC_LOAD: permOk = winCfg[`PMPC_BIT_R];
            PMPC_ACC_STORE: permOk = winCfg[`PMPC_BIT_W];
            default: permOk = winCfg[`PMPC_BIT_X];
        endcase
    end

    // decision always uses the settings held right now
    always_comb begin
        if (!anyHit) begin
            fault = !effMach && (NUM_ENTRIES > 0);
        end else if (!winFull) begin
            fault = 1'b1;
        end else if (effMach && !winCfg[`PMPC_BIT_L]) begin
            fault = 1'b0;
        end else begin
            fault = !permOk;
        end
    end

    // Next-state logic for settings and results
    always_comb begin
        logic [7:0] wcfg;
        wcfg = cfgWrData;
        st_d = st_q;
        // reserved write-only combination keeps store clear
        if (!wcfg[`PMPC_BIT_R]) begin
            wcfg[`PMPC_BIT_W] = 1'b0;
        end
        // Four-byte mode not selectable on a coarse grain
        if (GRAIN >= 1 && wcfg[`PMPC_A_HI:`PMPC_A_LO] == PMPC_FOUR_BYTE_ALIGNED) begin
            wcfg[`PMPC_A_HI:`PMPC_A_LO] = PMPC_MODE_OFF;
        end
        if (cfgWrEn && 32'(cfgWrIdx) < NUM_ENTRIES &&
            !st_q.cfg[cfgWrIdx][`PMPC_BIT_L]) begin
            st_d.cfg[cfgWrIdx] = wcfg;
        end
        if (addrWrEn && 32'(addrWrIdx) < NUM_ENTRIES &&
            !addrBlocked(st_q, addrWrIdx)) begin
            st_d.addr[addrWrIdx] = addrWrData;
        end
        // each part answered alone, nothing is held back
        st_d.rspValid = reqValid;
        st_d.rspFault = reqValid && fault;
        // fault kind by type, instruction fault gathered
        st_d.kind = '0;
        if (reqValid && fault) begin
            st_d.kind[reqType] = 1'b1;
        end
        st_d.groupValid = reqValid && reqLast;
        st_d.groupFault = reqValid && reqLast && (st_q.accFault || fault);
        if (reqValid) begin
            st_d.accFault = !reqLast && (st_q.accFault || fault);
        end
    end

    // All state in one register; clock enable freezes it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    assign rspValid = st_q.rspValid;
    assign rspFault = st_q.rspFault;
    assign faultInstr = st_q.kind[PMPC_ACC_FETCH];
    assign faultLoad = st_q.kind[PMPC_ACC_LOAD];
    assign faultStore = st_q.kind[PMPC_ACC_STORE];
    assign groupValid = st_q.groupValid;
    assign groupFault = st_q.groupFault;
    always_comb begin
        for (int i = 0; i < `PMPC_MAX_ENTRIES; i++) begin
            lockedMask[i] = st_q.cfg[i][`PMPC_BIT_L];
        end
    end

    // Reserved write-only permission must never sit in any entry
    always_comb begin
        reservedSeen = 1'b0;
        for (int i = 0; i < `PMPC_MAX_ENTRIES; i++) begin
            reservedSeen = reservedSeen |
                (!st_q.cfg[i][`PMPC_BIT_R] && st_q.cfg[i][`PMPC_BIT_W]);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_req;
        clkEn && reqValid;
    endsequence
    // A request that the decision turns down
    sequence s_fail;
        clkEn && reqValid && fault;
    endsequence

    a_cfg_lock_hold: assert property (clkEn && cfgWrEn && lockedMask[cfgWrIdx]
        |=> $stable(st_q.cfg)) else $error("frozen config changed");
    a_addr_lock_hold: assert property (clkEn && addrWrEn && addrBlocked(st_q, addrWrIdx)
        |=> $stable(st_q.addr)) else $error("protected address changed");
    a_lock_sticky: assert property ((($past(lockedMask) & ~lockedMask) == '0))
        else $error("freeze bit dropped");
    a_resp_latency: assert property (s_req |=> rspValid)
        else $error("no answer one cycle after request");
    a_mach_nomatch: assert property (s_req and (!anyHit && effMach) |=> !rspFault)
        else $error("unmatched machine access faulted");
    a_su_nomatch: assert property (s_req and (!anyHit && !effMach) |=> rspFault)
        else $error("unmatched lower access passed");
    a_partial_fail: assert property (s_req and (anyHit && !winFull) |=> rspFault)
        else $error("partial cover passed");
    a_fault_kind: assert property (rspFault == $onehot({faultInstr, faultLoad, faultStore}))
        else $error("fault kind mismatch");
    a_walk_priv: assert property (s_req and (reqPageWalk && !anyHit) |=> rspFault)
        else $error("page walk checked as machine");
    a_group_fault: assert property (s_req and (reqLast && fault) |=> groupValid && groupFault)
        else $error("instruction fault lost");
    // Outcome of a full match and the kind that a refusal raises
    a_mach_open: assert property (s_req and
        (anyHit && winFull && effMach && !winCfg[`PMPC_BIT_L]) |=> !rspFault)
        else $error("open machine access faulted");
    a_perm_deny: assert property (s_req and
        (anyHit && winFull && !permOk && !(effMach && !winCfg[`PMPC_BIT_L])) |=> rspFault)
        else $error("missing permission passed");
    a_instr_kind: assert property (s_fail and (reqType == PMPC_ACC_FETCH)
        |=> faultInstr) else $error("fetch fault not flagged");
    a_load_kind: assert property (s_fail and (reqType == PMPC_ACC_LOAD)
        |=> faultLoad) else $error("load fault not flagged");
    a_store_kind: assert property (s_fail and (reqType == PMPC_ACC_STORE)
        |=> faultStore) else $error("store fault not flagged");
    a_cfg_write_lands: assert property (clkEn && cfgWrEn && !lockedMask[cfgWrIdx] &&
        (32'(cfgWrIdx) < NUM_ENTRIES)
        |=> lockedMask[$past(cfgWrIdx)] == $past(cfgWrData[`PMPC_BIT_L]))
        else $error("open config write lost");
    a_no_reserved: assert property (!reservedSeen)
        else $error("reserved permission stored");
endmodule : pmpc_checker
`default_nettype wire

// >>> rtl/pmpc_regs.svh
// Purpose: Named constants for the memory protection checker
// Assumes: 34-bit physical byte addresses, 32-bit address registers
// Notes: Included by the package and by the checker module
`ifndef PMPC_REGS_SVH
`define PMPC_REGS_SVH
`define PMPC_MAX_ENTRIES 16
`define PMPC_DEF_ENTRIES 16
`define PMPC_DEF_GRAIN 0
`define PMPC_PA_W 34
`define PMPC_ADDR_W 32
`define PMPC_CFG_W 8
`define PMPC_BIT_R 0
`define PMPC_BIT_W 1
`define PMPC_BIT_X 2
`define PMPC_A_LO 3
`define PMPC_A_HI 4
`define PMPC_BIT_L 7
`define PMPC_CFG_RST 8'h00
`define PMPC_ADDR_RST 32'h0000_0000
`define PMPC_PA_ZERO 34'h0_0000_0000
`define PMPC_PA_ONE 34'h0_0000_0001
`define PMPC_WORD_SH 2
`endif

// >>> rtl/pmpc_pkg.sv
// Purpose: Types shared by the memory protection checker
// Assumes: Constants come from pmpc_regs.svh
// Notes: Privilege code 2'b10 is not a legal mode
`include "pmpc_regs.svh"
package pmpc_pkg;
    typedef enum logic [1:0] {
        PMPC_MODE_OFF = 2'h0,
        PMPC_RANGE_TOP_MODE = 2'h1,
        PMPC_FOUR_BYTE_ALIGNED = 2'h2,
        PMPC_POW2_ALIGNED_REGION = 2'h3
    } pmpc_match_t;
    typedef enum logic [1:0] {
        PMPC_ACC_FETCH = 2'h0,
        PMPC_ACC_LOAD = 2'h1,
        PMPC_ACC_STORE = 2'h2
    } pmpc_acc_t;
    typedef enum logic [1:0] {
        PMPC_PRIV_U = 2'h0,
        PMPC_PRIV_S = 2'h1,
        PMPC_PRIV_M = 2'h3
    } pmpc_priv_t;
    typedef struct packed {
        logic [`PMPC_MAX_ENTRIES-1:0][`PMPC_CFG_W-1:0] cfg;
        logic [`PMPC_MAX_ENTRIES-1:0][`PMPC_ADDR_W-1:0] addr;
        logic accFault;
        logic rspValid;
        logic rspFault;
        logic [2:0] kind;
        logic groupValid;
        logic groupFault;
    } pmpc_state_t;
endpackage : pmpc_pkg

// >>> verification/pmpc_core_model.sv
// Purpose: Core-side requester feeding the protection checker
// Assumes: Requests launch on the falling edge and are held across the sampling edge
// Notes: Released lines other than reqPriv flip so a stale request never looks valid
`timescale 1ns/10ps
`default_nettype none
module pmpc_core_model (
    input wire logic core_clk,
    output logic reqValid,
    output logic [33:0] reqAddr,
    output logic [1:0] reqSizeLog,
    output logic [1:0] reqType,
    output logic [1:0] reqPriv,
    output logic reqPageWalk,
    output logic reqLast
);
    // Idle at time zero
    initial begin
        reqValid = 1'b0;
        reqAddr = 34'h0_0000_0000;
        {reqSizeLog, reqType, reqPriv, reqPageWalk, reqLast} = 8'h00;
    end
    task automatic issue(input logic [33:0] a, input logic [1:0] s, input logic [1:0] t,
                         input logic [1:0] p, input logic w, input logic l);
        @(negedge core_clk);
        reqValid = 1'b1;
        reqAddr = a;
        {reqSizeLog, reqType, reqPriv, reqPageWalk, reqLast} = {s, t, p, w, l};
    endtask : issue
    // Drop the request; qualifiers other than reqPriv invert rather than keep old values
    task automatic rest();
        @(negedge core_clk);
        reqValid = 1'b0;
        reqAddr = ~reqAddr;
        {reqSizeLog, reqType, reqPageWalk, reqLast} = ~{reqSizeLog, reqType, reqPageWalk, reqLast};
    endtask : rest
endmodule : pmpc_core_model
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the protection checker
// Assumes: Expected faults worked out per scenario from entry setup
// Notes: Responses are matched in order against a queue of notes
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pmpc_pkg::*;
    localparam logic [1:0] FE = PMPC_ACC_FETCH, LD = PMPC_ACC_LOAD, ST = PMPC_ACC_STORE;
    localparam logic [1:0] US = PMPC_PRIV_U, SU = PMPC_PRIV_S, MA = PMPC_PRIV_M;
    logic core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, cfgWrEn = 1'b0, addrWrEn = 1'b0;
    logic [3:0] cfgWrIdx = 4'h0, addrWrIdx = 4'h0;
    logic [7:0] cfgWrData = 8'h00;
    logic [31:0] addrWrData = 32'h0000_0000;
    logic reqValid, reqPageWalk, reqLast, rspValid, rspFault, faultInstr, faultLoad;
    logic faultStore, groupValid, groupFault;
    logic [33:0] reqAddr;
    logic [1:0] reqSizeLog, reqType, reqPriv, p;
    logic [15:0] lockedMask;
    logic [5:0] expQ[$];
    logic gAcc = 1'b0;
    int failures = 0, check_count = 0;
    always #2 core_clk = ~core_clk;
    pmpc_core_model u_pmpc_core_model (.core_clk(core_clk), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqSizeLog(reqSizeLog), .reqType(reqType), .reqPriv(reqPriv),
        .reqPageWalk(reqPageWalk), .reqLast(reqLast));
    pmpc_checker #(.NUM_ENTRIES(16), .GRAIN(0)) u_pmpc_checker (.core_clk(core_clk),
        .resetn(resetn), .clkEn(clkEn), .cfgWrEn(cfgWrEn), .cfgWrIdx(cfgWrIdx),
        .cfgWrData(cfgWrData), .addrWrEn(addrWrEn), .addrWrIdx(addrWrIdx),
        .addrWrData(addrWrData), .reqValid(reqValid), .reqAddr(reqAddr),
        .reqSizeLog(reqSizeLog), .reqType(reqType), .reqPriv(reqPriv),
        .reqPageWalk(reqPageWalk), .reqLast(reqLast), .rspValid(rspValid),
        .rspFault(rspFault), .faultInstr(faultInstr), .faultLoad(faultLoad),
        .faultStore(faultStore), .groupValid(groupValid), .groupFault(groupFault),
        .lockedMask(lockedMask));
    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic rst();
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
    endtask : rst
    // no paging here, so settings take hold with no fence
    // Register write; the core goes idle first so no request repeats meanwhile
    task automatic wr(input logic c, input logic [3:0] i, input logic [31:0] d);
        u_pmpc_core_model.rest();
        {cfgWrEn, addrWrEn, cfgWrIdx, addrWrIdx, cfgWrData, addrWrData} = {c, !c, i, i, d[7:0], d};
        @(negedge core_clk);
        {cfgWrEn, addrWrEn, cfgWrData, addrWrData} = {2'b00, ~d[7:0], ~d};
    endtask : wr
    // Note the expected result, then launch the request
    task automatic t(input logic [33:0] a, input logic [1:0] s, input logic [1:0] ty,
                     input logic [1:0] pr, input logic w, input logic l, input logic f);
        logic [2:0] k;
        k = (ty == FE) ? 3'b100 : (ty == LD) ? 3'b010 : 3'b001;
        gAcc = gAcc | f;
        expQ.push_back({f, k & {3{f}}, l, gAcc & l});
        if (l) begin
            gAcc = 1'b0;
        end
        u_pmpc_core_model.issue(a, s, ty, pr, w, l);
    endtask : t
    task automatic drain();
        u_pmpc_core_model.rest();
        repeat (3) @(negedge core_clk);
        chk("notes left", 34'(expQ.size()), 34'h0);
    endtask : drain
    // Oldest note against each response; kinds only count alongside a fault
    always @(posedge core_clk) begin
        #1;
        if (rspValid === 1'b1) begin
            chk("note present", 34'(expQ.size() != 0), 34'h1);
            if (expQ.size() != 0) begin
                chk("response", 34'({rspFault, {faultInstr, faultLoad, faultStore} & {3{rspFault}},
                    groupValid, groupFault & groupValid}), 34'(expQ.pop_front()));
            end
        end
    end
    // Run takes under 2000 ns; the limit leaves a wide margin
    initial begin
        #20000;
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(81571));
        rst();
        chk("lock mask", 34'(lockedMask), 34'h0);
        t(34'h0_0000_0100, 2'h2, LD, MA, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_0100, 2'h2, LD, SU, 1'b0, 1'b1, 1'b1);
        wr(1'b0, 4'h0, 32'h0000_0003);
        wr(1'b1, 4'h0, 32'h0000_0011);
        t(34'h0_0000_000B, 2'h3, LD, US, 1'b0, 1'b1, 1'b1);
        t(34'h0_0000_000C, 2'h2, LD, US, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_000C, 2'h2, ST, US, 1'b0, 1'b1, 1'b1);
        t(34'h0_0000_000C, 2'h2, ST, MA, 1'b0, 1'b1, 1'b0);
        wr(1'b1, 4'h0, 32'h0000_0091);
        t(34'h0_0000_000C, 2'h2, ST, MA, 1'b0, 1'b1, 1'b1);
        wr(1'b1, 4'h0, 32'h0000_0017);
        wr(1'b0, 4'h0, 32'h0000_0010);
        t(34'h0_0000_000C, 2'h2, ST, US, 1'b0, 1'b1, 1'b1);
        t(34'h0_0000_000C, 2'h2, LD, US, 1'b0, 1'b1, 1'b0);
        wr(1'b0, 4'h1, 32'h0000_0020);
        wr(1'b0, 4'h2, 32'h0000_0040);
        wr(1'b1, 4'h2, 32'h0000_008C);
        t(34'h0_0000_0080, 2'h2, FE, US, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_00FC, 2'h2, FE, US, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_0100, 2'h2, FE, US, 1'b0, 1'b1, 1'b1);
        wr(1'b0, 4'h1, 32'h0000_0000);
        t(34'h0_0000_007C, 2'h2, FE, US, 1'b0, 1'b1, 1'b1);
        wr(1'b1, 4'h3, 32'h0000_0080);
        wr(1'b1, 4'h3, 32'h0000_001F);
        chk("lock mask", 34'(lockedMask), 34'h0_0000_000D);
        wr(1'b0, 4'h4, 32'h0000_0401);
        wr(1'b1, 4'h4, 32'h0000_001B);
        t(34'h0_0000_100C, 2'h2, LD, SU, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_1010, 2'h2, LD, SU, 1'b0, 1'b1, 1'b1);
        wr(1'b0, 4'h6, 32'h0000_0403);
        wr(1'b1, 4'h6, 32'h0000_001F);
        t(34'h0_0000_1010, 2'h2, LD, SU, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_1000, 2'h2, FE, SU, 1'b0, 1'b1, 1'b1);
        wr(1'b0, 4'h5, 32'h0000_0800);
        wr(1'b1, 4'h5, 32'h0000_001A);
        t(34'h0_0000_2000, 2'h2, ST, SU, 1'b0, 1'b1, 1'b1);
        t(34'h0_0000_3000, 2'h2, LD, MA, 1'b1, 1'b1, 1'b1);
        t(34'h0_0000_3000, 2'h2, LD, US, 1'b0, 1'b0, 1'b1);
        t(34'h0_0000_100C, 2'h2, LD, US, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_1008, 2'h2, LD, US, 1'b0, 1'b0, 1'b0);
        t(34'h0_0000_100C, 2'h2, LD, US, 1'b0, 1'b1, 1'b0);
        // High half of the space holds no entry; only machine mode passes there
        repeat (24) begin
            p = ($urandom_range(1) != 0) ? MA : 2'($urandom_range(1));
            t({2'b10, 32'($urandom)} & ~34'h0_0000_0007, 2'($urandom_range(3)),
              2'($urandom_range(2)), p, 1'b0, 1'b1, p != MA);
        end
        drain();
        rst();
        chk("lock mask", 34'(lockedMask), 34'h0);
        // A write made while the clock enable is low must not land
        clkEn = 1'b0;
        wr(1'b1, 4'h0, 32'h0000_0080);
        clkEn = 1'b1;
        chk("frozen write", 34'(lockedMask), 34'h0);
        t(34'h0_0000_000C, 2'h2, ST, MA, 1'b0, 1'b1, 1'b0);
        t(34'h0_0000_000C, 2'h2, ST, US, 1'b0, 1'b1, 1'b1);
        drain();
        close_out();
    end
endmodule : testbench
`default_nettype wire
